//--- rtl/ldc_ctrl.sv
// serial-controlled control register bank of a six-channel led driver
// assumes sda/scl pins with external pull-up; one core clock
//
// What this block does
// - bytes are eight bits, msb first
// - device pulls data low on ninth clock
// - 0x00 bit2 switches group a leds
// - 0x00 bit1 switches group b leds
// - 0x00 bit0 soft reset, self clears
// - 0x10 bits5..0 enable outputs six..one
// - 0x20 bit7 enables interrupt; 0x40 read clears
// - 0x20 bit6 selects linear curve, group a
// - 0x20 bits3,2 put six,five in group a
// - 0x20 bit1 sets pwm input polarity
// - 0x20 bit0 makes pwm input effective
// - 0x30 bits7:6 pick pump filter time
// - 0x30 bits5:3 pick ramp-down step time
// - 0x30 bits2:0 pick ramp-up step time
// - write is address, register, data bytes
// - answer only address 0111000, r/w bit
// - enable pin low resets and disables
`timescale 1ns/10ps
module ldc_ctrl
  import ldc_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  input  wire logic       hardware_enable_pin,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  input  wire logic       pwm_in,
  input  wire logic       pending_event,
  output logic            int_out,
  output logic            group_a_on,
  output logic            group_b_on,
  output logic            output_one_on,
  output logic            output_two_on,
  output logic            output_three_on,
  output logic            output_four_on,
  output logic            output_five_on,
  output logic            output_six_on,
  output logic            output_five_group_select,
  output logic            output_six_group_select,
  output logic            linear_curve,
  output logic            pwm_level,
  output logic      [1:0] gain_change_filter,
  output logic      [2:0] ramp_down_step,
  output logic      [2:0] ramp_up_step,
  output logic            readback_strobe
);
  // ------------------------------------------------------------
  // pin synchronisers and enable-pin reset
  // ------------------------------------------------------------
  logic [2:0] scl_sync;
  logic [2:0] sda_sync;
  logic [2:0] hardware_enable_pin_sync;
  logic [2:0] pwm_sync;
  logic       scl_q;
  logic       sda_q;
  logic       hardware_enable_pin_q;
  logic       pwm_q;
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      scl_sync  <= 3'b111;
      sda_sync  <= 3'b111;
      hardware_enable_pin_sync <= 3'b000;
      pwm_sync  <= 3'b000;
    end
    else
    begin
      scl_sync  <= {scl_sync[1:0], scl_in};
      sda_sync  <= {sda_sync[1:0], sda_in};
      hardware_enable_pin_sync <= {hardware_enable_pin_sync[1:0], hardware_enable_pin};
      pwm_sync  <= {pwm_sync[1:0], pwm_in};
    end
  end

  // a change counts once stages two and three agree
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      scl_q  <= 1'b1;
      sda_q  <= 1'b1;
      hardware_enable_pin_q <= 1'b0;
      pwm_q  <= 1'b0;
    end
    else
    begin
      if (scl_sync[1] == scl_sync[2])
        scl_q <= scl_sync[2];
      if (sda_sync[1] == sda_sync[2])
        sda_q <= sda_sync[2];
      if (hardware_enable_pin_sync[1] == hardware_enable_pin_sync[2])
        hardware_enable_pin_q <= hardware_enable_pin_sync[2];
      if (pwm_sync[1] == pwm_sync[2])
        pwm_q <= pwm_sync[2];
    end
  end
  logic scl_d;
  logic sda_d;
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end
    else
    begin
      scl_d <= scl_q;
      sda_d <= sda_q;
    end
  end
  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;
  logic hardware_enable_pin_low;
  assign scl_rise   = scl_q & ~scl_d;
  assign scl_fall   = ~scl_q & scl_d;
  assign start_cond = scl_q & scl_d & sda_d & ~sda_q;
  assign stop_cond  = scl_q & scl_d & ~sda_d & sda_q;
  assign hardware_enable_pin_low   = ~hardware_enable_pin_q;

  // ------------------------------------------------------------
  // serial engine
  // ------------------------------------------------------------
  ldc_state_t state;
  logic [7:0] shift;
  logic [3:0] bit_cnt;
  logic [1:0] byte_idx;
  logic [7:0] reg_addr;
  logic       read_dir;
  logic       wr_pulse;
  logic       soft_clear;
  logic [7:0] rdata;

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state           <= LDC_IDLE;
      shift           <= 8'h00;
      bit_cnt         <= 4'h0;
      byte_idx        <= 2'b00;
      reg_addr        <= 8'h00;
      read_dir        <= 1'b0;
      wr_pulse        <= 1'b0;
      soft_clear      <= 1'b0;
      sda_out         <= 1'b0;
      sda_oe          <= 1'b0;
      readback_strobe <= 1'b0;
    end
    else if (hardware_enable_pin_low)
    begin
      state           <= LDC_IDLE;
      reg_addr        <= 8'h00;
      wr_pulse        <= 1'b0;
      soft_clear      <= 1'b0;
      sda_oe          <= 1'b0;
      readback_strobe <= 1'b0;
    end
    else
    begin
      wr_pulse        <= 1'b0;
      soft_clear      <= 1'b0;
      readback_strobe <= 1'b0;
      if (stop_cond)
      begin
        state  <= LDC_IDLE;
        sda_oe <= 1'b0;
      end
      else if (start_cond)
      begin
        state    <= LDC_RECV;  // repeated start acts like start
        bit_cnt  <= 4'h0;
        byte_idx <= 2'b00;
        sda_oe   <= 1'b0;
      end
      else
      begin
        case (state)
          LDC_IDLE:
            sda_oe <= 1'b0;
          LDC_RECV:
          begin
            if (scl_rise)
            begin
              shift   <= {shift[6:0], sda_q};
              bit_cnt <= bit_cnt + 4'h1;
            end
            else if (scl_fall && bit_cnt == 4'h8)
            begin
              bit_cnt <= 4'h0;
              if (byte_idx == 2'b00)
              begin
                if (shift[7:1] == LDC_DEV_ADDR)
                begin
                  read_dir <= shift[0];
                  sda_oe   <= 1'b1;
                  state    <= LDC_ACK;
                end
                else
                  state <= LDC_IDLE;
              end
              else if (byte_idx == 2'b01)
              begin
                reg_addr <= shift;
                sda_oe   <= 1'b1;
                state    <= LDC_ACK;
              end
              else
              begin
                sda_oe <= 1'b1;
                state  <= LDC_ACK;
                if (reg_addr == LDC_OFS_GROUP && shift[LDC_SOFT_RST])
                  soft_clear <= 1'b1;
                else
                  wr_pulse <= 1'b1;
              end
            end
          end
          LDC_ACK:
          begin
            // ninth pulse clocked by the master
            if (scl_fall)
            begin
              sda_oe <= 1'b0;
              if (byte_idx != 2'b10)
                byte_idx <= byte_idx + 2'b01;
              if (read_dir)
              begin
                state   <= LDC_SEND;
                shift   <= rdata;
                sda_oe  <= ~rdata[7];
                bit_cnt <= 4'h0;
                if (reg_addr == LDC_OFS_READBK)
                  readback_strobe <= 1'b1;
              end
              else
                state <= LDC_RECV;
            end
          end
          LDC_SEND:
          begin
            if (scl_fall)
            begin
              if (bit_cnt == 4'h7)
              begin
                sda_oe <= 1'b0;
                state  <= LDC_RACK;
              end
              else
              begin
                shift   <= {shift[6:0], 1'b0};
                sda_oe  <= ~shift[6];
                bit_cnt <= bit_cnt + 4'h1;
              end
            end
          end
          LDC_RACK:
          begin
            if (scl_rise)
            begin
              if (sda_q)
                state <= LDC_IDLE;
            end
            else if (scl_fall)
            begin
              state   <= LDC_SEND;
              shift   <= rdata;
              sda_oe  <= ~rdata[7];
              bit_cnt <= 4'h0;
            end
          end
          default:
            state <= LDC_IDLE;
        endcase
      end
    end
  end

  // ------------------------------------------------------------
  // register store
  // ------------------------------------------------------------
  logic [7:0] group_reg;
  logic [7:0] outen_reg;
  logic [7:0] setup_reg;
  logic [7:0] timing_reg;

  ldc_regfile u_regs (
    .core_clk   (core_clk),
    .rst_n      (rst_n),
    .clear      (soft_clear | hardware_enable_pin_low),
    .wr_en      (wr_pulse),
    .addr       (reg_addr),
    .wdata      (shift),
    .rdata      (rdata),
    .group_reg  (group_reg),
    .outen_reg  (outen_reg),
    .setup_reg  (setup_reg),
    .timing_reg (timing_reg)
  );

  // ------------------------------------------------------------
  // registered control outputs
  // ------------------------------------------------------------
  logic int_pending;

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      int_pending <= 1'b0;
    else if (pending_event)
      int_pending <= 1'b1;  // set wins over clear
    else if (readback_strobe || hardware_enable_pin_low)
      int_pending <= 1'b0;
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      int_out                  <= 1'b0;
      group_a_on               <= 1'b0;
      group_b_on               <= 1'b0;
      output_one_on            <= 1'b0;
      output_two_on            <= 1'b0;
      output_three_on          <= 1'b0;
      output_four_on           <= 1'b0;
      output_five_on           <= 1'b0;
      output_six_on            <= 1'b0;
      output_five_group_select <= 1'b1;
      output_six_group_select  <= 1'b1;
      linear_curve             <= 1'b0;
      pwm_level                <= 1'b0;
      gain_change_filter       <= 2'b00;
      ramp_down_step           <= 3'b000;
      ramp_up_step             <= 3'b000;
    end
    else
    begin
      int_out         <= setup_reg[LDC_INT_EN_BIT] & int_pending;
      group_a_on      <= hardware_enable_pin_q & group_reg[LDC_GRP_A_BIT];
      group_b_on      <= hardware_enable_pin_q & group_reg[LDC_GRP_B_BIT];
      output_one_on   <= hardware_enable_pin_q & outen_reg[0];
      output_two_on   <= hardware_enable_pin_q & outen_reg[1];
      output_three_on <= hardware_enable_pin_q & outen_reg[2];
      output_four_on  <= hardware_enable_pin_q & outen_reg[3];
      output_five_on  <= hardware_enable_pin_q & outen_reg[4];
      output_six_on   <= hardware_enable_pin_q & outen_reg[5];
      output_five_group_select <= setup_reg[LDC_FIVE_SEL_BIT];
      output_six_group_select  <= setup_reg[LDC_SIX_SEL_BIT];
      linear_curve    <= setup_reg[LDC_LIN_BIT];
      // pwm level as seen by dimming, after polarity and enable
      pwm_level       <= setup_reg[LDC_PWM_EN_BIT]
                         & (pwm_q ^ setup_reg[LDC_PWM_POL_BIT]);
      gain_change_filter <= timing_reg[7:6];
      ramp_down_step     <= timing_reg[5:3];
      ramp_up_step       <= timing_reg[2:0];
    end
  end
endmodule

//--- rtl/ldc_pkg.sv
// constants for the led driver control register bank
// assumes a 25 MHz core clock and a two-wire serial host
package ldc_pkg;
  // ------------------------------------------------------------
  // bus address and register offsets
  // ------------------------------------------------------------
  localparam logic [6:0] LDC_DEV_ADDR    = 7'h38;
  localparam logic [7:0] LDC_OFS_GROUP   = 8'h00;
  localparam logic [7:0] LDC_OFS_OUTEN   = 8'h10;
  localparam logic [7:0] LDC_OFS_SETUP   = 8'h20;
  localparam logic [7:0] LDC_OFS_TIMING  = 8'h30;
  localparam logic [7:0] LDC_OFS_READBK  = 8'h40;
  // ------------------------------------------------------------
  // field positions
  // ------------------------------------------------------------
  localparam int LDC_GRP_A_BIT   = 2;
  localparam int LDC_GRP_B_BIT   = 1;
  localparam int LDC_SOFT_RST    = 0;
  localparam int LDC_INT_EN_BIT  = 7;
  localparam int LDC_LIN_BIT     = 6;
  localparam int LDC_SIX_SEL_BIT = 3;
  localparam int LDC_FIVE_SEL_BIT = 2;
  localparam int LDC_PWM_POL_BIT = 1;
  localparam int LDC_PWM_EN_BIT  = 0;
  // ------------------------------------------------------------
  // writable masks and reset values
  // ------------------------------------------------------------
  localparam logic [7:0] LDC_GROUP_MASK  = 8'h06;
  localparam logic [7:0] LDC_OUTEN_MASK  = 8'h3F;
  localparam logic [7:0] LDC_SETUP_MASK  = 8'hCF;
  localparam logic [7:0] LDC_TIMING_MASK = 8'hFF;
  localparam logic [7:0] LDC_GROUP_RST   = 8'h00;
  localparam logic [7:0] LDC_OUTEN_RST   = 8'h00;
  localparam logic [7:0] LDC_SETUP_RST   = 8'h0C;
  localparam logic [7:0] LDC_TIMING_RST  = 8'h00;
  // ------------------------------------------------------------
  // protocol states
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    LDC_IDLE = 3'b000,
    LDC_RECV = 3'b001,
    LDC_ACK  = 3'b010,
    LDC_SEND = 3'b011,
    LDC_RACK = 3'b100
  } ldc_state_t;
endpackage

//--- rtl/ldc_regfile.sv
// four-word control register store with registered read data
// assumes writes come one at a time from the serial engine
`timescale 1ns/10ps
module ldc_regfile
  import ldc_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  input  wire logic       clear,
  input  wire logic       wr_en,
  input  wire logic [7:0] addr,
  input  wire logic [7:0] wdata,
  output logic      [7:0] rdata,
  output logic      [7:0] group_reg,
  output logic      [7:0] outen_reg,
  output logic      [7:0] setup_reg,
  output logic      [7:0] timing_reg
);
  // ------------------------------------------------------------
  // storage
  // ------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      group_reg  <= LDC_GROUP_RST;
      outen_reg  <= LDC_OUTEN_RST;
      setup_reg  <= LDC_SETUP_RST;
      timing_reg <= LDC_TIMING_RST;
    end
    else if (clear)
    begin
      group_reg  <= LDC_GROUP_RST;
      outen_reg  <= LDC_OUTEN_RST;
      setup_reg  <= LDC_SETUP_RST;
      timing_reg <= LDC_TIMING_RST;
    end
    else if (wr_en)
    begin
      case (addr)
        LDC_OFS_GROUP:  group_reg  <= wdata & LDC_GROUP_MASK;
        LDC_OFS_OUTEN:  outen_reg  <= wdata & LDC_OUTEN_MASK;
        LDC_OFS_SETUP:  setup_reg  <= wdata & LDC_SETUP_MASK;
        LDC_OFS_TIMING: timing_reg <= wdata & LDC_TIMING_MASK;
        default:        group_reg  <= group_reg;
      endcase
    end
  end

  // ------------------------------------------------------------
  // registered read port
  // ------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      rdata <= 8'h00;
    else
    begin
      case (addr)
        LDC_OFS_GROUP:  rdata <= group_reg;
        LDC_OFS_OUTEN:  rdata <= outen_reg;
        LDC_OFS_SETUP:  rdata <= setup_reg;
        LDC_OFS_TIMING: rdata <= timing_reg;
        default:        rdata <= 8'h00;
      endcase
    end
  end
endmodule

//--- bench/ldc_host_model.sv
// serial bus master model: drives scl, pulls sda low
// assumes sda_bus is the resolved wire with its pull-up
`timescale 1ns/10ps
module ldc_host_model
  import ldc_pkg::*;
(
  input  wire logic core_clk,
  input  wire logic sda_bus,
  output logic      scl,
  output logic      sda_low
);
  // ------
  // bus cycles
  // ------
  localparam int HALF = 10;
  initial
  begin
    scl     = 1'b1;
    sda_low = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  // data set while scl low, sampled at end of high
  task automatic bit_cyc(input logic low, output logic seen);
    sda_low = low;
    tick(HALF);
    scl = 1'b1;
    tick(HALF);
    seen = sda_bus;
    scl = 1'b0;
    tick(2);
  endtask
  task automatic start_c();
    sda_low = 1'b0;
    tick(HALF);
    scl = 1'b1;
    tick(HALF);
    sda_low = 1'b1;
    tick(HALF);
    scl = 1'b0;
    tick(2);
  endtask
  task automatic stop_c();
    sda_low = 1'b1;
    tick(HALF);
    scl = 1'b1;
    tick(HALF);
    sda_low = 1'b0;
    tick(HALF);
  endtask
  task automatic send(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_cyc(~b[i], s);
    bit_cyc(1'b0, s);
    ack = ~s;
  endtask
  task automatic wr(input logic [6:0] dev, input logic [7:0] r, v, output logic [2:0] a);
    start_c();
    send({dev, 1'b0}, a[2]);
    send(r, a[1]);
    send(v, a[0]);
    stop_c();
  endtask
  task automatic rd(input logic [7:0] r, output logic [7:0] d);
    logic a;
    start_c();
    send({LDC_DEV_ADDR, 1'b0}, a);
    send(r, a);
    start_c();
    send({LDC_DEV_ADDR, 1'b1}, a);
    for (int i = 7; i >= 0; i--)
      bit_cyc(1'b0, d[i]);
    bit_cyc(1'b0, a);
    stop_c();
  endtask
endmodule

//--- bench/ldc_ctrl_checker.sv
// port assertions for the led driver control bank
// assumes one core clock and active-low asynchronous reset
`timescale 1ns/10ps
module ldc_ctrl_checker
(
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  input  wire logic       hardware_enable_pin,
  input  wire logic       scl_in,
  input  wire logic       pending_event,
  input  wire logic       sda_out,
  input  wire logic       sda_oe,
  input  wire logic       int_out,
  input  wire logic       group_a_on,
  input  wire logic       output_six_group_select,
  input  wire logic       pwm_level,
  input  wire logic [2:0] ramp_up_step,
  input  wire logic       readback_strobe
);
  // ------
  // assertions
  // ------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  sequence pin_low_long;
    !hardware_enable_pin [*8];
  endsequence
  sequence strobe_quiet;
    (readback_strobe && !pending_event) ##1 !pending_event [*3];
  endsequence
  a_oe_drives_low: assert property (sda_oe |-> !sda_out)
    else $error("sda driven high");
  a_oe_rise_scl_low: assert property ($rose(sda_oe) |-> !scl_in)
    else $error("sda pulled while scl high");
  a_oe_stable_high: assert property (scl_in && $past(scl_in) |-> $stable(sda_oe))
    else $error("sda moved while scl high");
  a_strobe_one_cycle: assert property (readback_strobe |=> !readback_strobe)
    else $error("readback strobe too long");
  a_strobe_scl_low: assert property (readback_strobe |-> !scl_in)
    else $error("readback strobe with scl high");
  a_int_read_clears: assert property (strobe_quiet |-> !int_out)
    else $error("interrupt not cleared by readback");
  a_pin_low_defaults: assert property (pin_low_long |-> !group_a_on && !int_out
    && output_six_group_select && !pwm_level && ramp_up_step == 3'h0)
    else $error("enable pin low left settings");
  a_cfg_on_write: assert property ($changed({group_a_on, ramp_up_step})
    && hardware_enable_pin |-> !scl_in)
    else $error("setting changed outside a write");
endmodule

//--- bench/tb_top.sv
// top bench: clock, reset, open-drain bus, design, host model
// assumes the host model drives the bus at falling clock edges
`timescale 1ns/10ps
module tb_top
  import ldc_pkg::*;
;
  // ------
  // signals, design and host
  // ------
  logic       core_clk = 1'b0;
  logic       rst_n, hw_en, pwm_in, pending_event, scl, sda_low, sda_out, sda_oe, int_out;
  logic       group_a_on, group_b_on, output_five_group_select, output_six_group_select;
  logic       linear_curve, pwm_level, readback_strobe;
  logic [5:0] outs;
  logic [1:0] gain_change_filter;
  logic [2:0] ramp_down_step, ramp_up_step, a;
  logic [7:0] d, t;
  int         miscompares = 0;
  int         checks = 0;
  int         cycles = 0;
  wire logic  sda_bus = ~(sda_low | (sda_oe & ~sda_out));
  always #20 core_clk = ~core_clk;
  ldc_ctrl i_dut (.core_clk(core_clk), .rst_n(rst_n), .hardware_enable_pin(hw_en),
    .scl_in(scl), .sda_in(sda_bus), .sda_out(sda_out), .sda_oe(sda_oe), .pwm_in(pwm_in),
    .pending_event(pending_event), .int_out(int_out), .group_a_on(group_a_on),
    .group_b_on(group_b_on), .output_one_on(outs[0]), .output_two_on(outs[1]),
    .output_three_on(outs[2]), .output_four_on(outs[3]), .output_five_on(outs[4]),
    .output_six_on(outs[5]), .output_five_group_select(output_five_group_select),
    .output_six_group_select(output_six_group_select), .linear_curve(linear_curve),
    .pwm_level(pwm_level), .gain_change_filter(gain_change_filter),
    .ramp_down_step(ramp_down_step), .ramp_up_step(ramp_up_step),
    .readback_strobe(readback_strobe));
  ldc_host_model i_host (.core_clk(core_clk), .sda_bus(sda_bus), .scl(scl), .sda_low(sda_low));
  // ------
  // tasks
  // ------
  task automatic check(input string what, input logic [7:0] seen, exp);
    checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic wr_chk(input logic [6:0] dev, input logic [7:0] r, v, input logic [2:0] ack);
    i_host.wr(dev, r, v, a);
    wait_n(4);
    check("acks", {5'h00, a}, {5'h00, ack});
  endtask
  task automatic rd_chk(input logic [7:0] r, exp);
    i_host.rd(r, d);
    check("readback", d, exp);
  endtask
  task automatic check_cfg(input logic [7:0] g, e, s, tm);
    check("group", {5'h00, group_a_on, group_b_on, 1'b0}, g);
    check("outen", {2'h0, outs}, e);
    check("setup", {1'b0, linear_curve, 2'h0, output_six_group_select,
      output_five_group_select, 2'h0}, s & 8'h4C);
    check("timing", {gain_change_filter, ramp_down_step, ramp_up_step}, tm);
  endtask
  task automatic pulse_event();
    pending_event = 1'b1;
    wait_n(1);
    pending_event = 1'b0;
    wait_n(4);
  endtask
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 90000)
    begin
      miscompares++;
      print_verdict();
    end
  end
  // ------
  // tests
  // ------
  localparam logic [7:0] OFS [4] = '{8'h00, 8'h10, 8'h20, 8'h30};
  localparam logic [7:0] RST [4] = '{8'h00, 8'h00, 8'h0C, 8'h00};
  localparam logic [7:0] WRV [4] = '{8'hFE, 8'hFF, 8'hFF, 8'hFF};
  localparam logic [7:0] RDV [4] = '{8'h06, 8'h3F, 8'hCF, 8'hFF};
  localparam logic [7:0] PS [5] = '{8'h01, 8'h01, 8'h03, 8'h03, 8'h02};
  localparam logic [4:0] PWM_IN  = 5'b01001;
  localparam logic [4:0] PWM_EXP = 5'b00101;
  initial
  begin
    rst_n = 1'b0;
    hw_en = 1'b1;
    pwm_in = 1'b0;
    pending_event = 1'b0;
    wait_n(5);
    rst_n = 1'b1;
    wait_n(8);
    check_cfg(8'h00, 8'h00, 8'h0C, 8'h00);
    for (int i = 0; i < 4; i++)
    begin
      rd_chk(OFS[i], RST[i]);
      wr_chk(LDC_DEV_ADDR, OFS[i], WRV[i], 3'h7);
      rd_chk(OFS[i], RDV[i]);
    end
    check_cfg(8'h06, 8'h3F, 8'hFF, 8'hFF);
    check("pwm", {7'h00, pwm_level}, 8'h01);
    pulse_event();
    check("int", {7'h00, int_out}, 8'h01);
    rd_chk(LDC_OFS_READBK, 8'h00);
    wait_n(3);
    check("int", {7'h00, int_out}, 8'h00);
    for (int i = 0; i < 8; i++)
    begin
      t = {i[1:0], i[2:0], ~i[2:0]};
      wr_chk(LDC_DEV_ADDR, LDC_OFS_TIMING, t, 3'h7);
      check("timing", {gain_change_filter, ramp_down_step, ramp_up_step}, t);
    end
    for (int i = 0; i < 5; i++)
    begin
      wr_chk(LDC_DEV_ADDR, LDC_OFS_SETUP, PS[i], 3'h7);
      pwm_in = PWM_IN[i];
      wait_n(8);
      check("pwm", {7'h00, pwm_level}, {7'h00, PWM_EXP[i]});
    end
    pulse_event();
    check("int", {7'h00, int_out}, 8'h00);
    wr_chk(LDC_DEV_ADDR, LDC_OFS_SETUP, 8'h80, 3'h7);
    check("int", {7'h00, int_out}, 8'h01);
    wr_chk(7'h39, LDC_OFS_OUTEN, 8'h00, 3'h0);
    check("outen", {2'h0, outs}, 8'h3F);
    wr_chk(LDC_DEV_ADDR, 8'h50, 8'hFF, 3'h7);
    rd_chk(8'h50, 8'h00);
    wr_chk(LDC_DEV_ADDR, LDC_OFS_GROUP, 8'h01, 3'h7);
    check_cfg(8'h00, 8'h00, 8'h0C, 8'h00);
    rd_chk(LDC_OFS_GROUP, 8'h00);
    wr_chk(LDC_DEV_ADDR, LDC_OFS_OUTEN, 8'h15, 3'h7);
    hw_en = 1'b0;
    wait_n(20);
    check_cfg(8'h00, 8'h00, 8'h0C, 8'h00);
    hw_en = 1'b1;
    wait_n(8);
    rd_chk(LDC_OFS_OUTEN, 8'h00);
    print_verdict();
  end
endmodule
bind ldc_ctrl ldc_ctrl_checker i_chk (.core_clk(core_clk), .rst_n(rst_n),
  .hardware_enable_pin(hardware_enable_pin), .scl_in(scl_in), .pending_event(pending_event),
  .sda_out(sda_out), .sda_oe(sda_oe), .int_out(int_out), .group_a_on(group_a_on),
  .output_six_group_select(output_six_group_select), .pwm_level(pwm_level),
  .ramp_up_step(ramp_up_step), .readback_strobe(readback_strobe));
